// file: core/emst_pkg.sv
// Purpose: Shared constants and types for the external bus strobe timing block.
// Assumes: One system clock at 20 MHz; the timing register sits on the byte-wide special register port.
// Notes:   Field layout of the timing register follows the packed struct below, msb first.
//
// Behaviour
// - Insert a setup interval of 0 to 3 clocks before every strobe.
// - Strobe stays active for the width field plus one clocks, 1 to 16.
// - Read and write strobes share one width setting.
// - Address and control stay stable 0 to 3 clocks after the strobe.
// - Hold selection occupies bits 1:0 of the timing register.
// - All intervals are counted in whole system clock periods.
package emst_pkg;

  // Byte address of the timing register on the special register port.
  localparam logic [7:0] EMST_TC_ADDR      = 8'haf;
  // All fields come out of reset at their longest setting.
  localparam logic [7:0] EMST_TC_RESET     = 8'hff;
  localparam int         EMST_SETUP_LSB    = 6;
  localparam int         EMST_WIDTH_LSB    = 2;
  localparam int         EMST_HOLD_LSB     = 0;

  // One interval unit is one system clock period.
  localparam int         EMST_CLK_PERIOD_NS = 50;
  localparam int         EMST_UNIT_NS       = 50;
  localparam int         EMST_CYC_PER_UNIT  = (EMST_UNIT_NS + EMST_CLK_PERIOD_NS - 1) / EMST_CLK_PERIOD_NS;

  localparam logic [3:0] EMST_CNT_ZERO     = 4'h0;
  localparam logic [3:0] EMST_CNT_ONE      = 4'h1;
  localparam logic [4:0] EMST_RUN_ZERO     = 5'h00;

  typedef struct packed {
    logic [1:0] setup;   // addr_setup_sel
    logic [3:0] width;   // strobe_width_sel
    logic [1:0] hold;    // addr_hold_sel
  } emst_timing_s;

  typedef struct packed {
    logic        write;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } emst_req_s;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_SETUP,
    ST_STROBE,
    ST_HOLD
  } emst_state_e;

endpackage

// file: core/emst_phase_timer.sv
// Purpose: Down counter that times one phase of an external bus cycle.
// Assumes: Loaded with phase length minus one on the edge that enters the phase.
// Notes:   zero is combinational; the caller registers anything that leaves the block.
`timescale 1ns/10ps
module emst_phase_timer (
  input  wire logic       clk,       // System clock.
  input  wire logic       rst_b,     // Asynchronous reset, active low.
  input  wire logic       load,      // Start a new phase.
  input  wire logic [3:0] load_val,  // Phase length minus one.
  output logic            zero       // Last cycle of the current phase.
);
  import emst_pkg::*;

  logic [3:0] cnt_ff;

  // One count per clock period, no prescaler.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_ff <= EMST_CNT_ZERO;
    end else if (load) begin
      cnt_ff <= load_val;
    end else if (cnt_ff != EMST_CNT_ZERO) begin
      cnt_ff <= cnt_ff - EMST_CNT_ONE;
    end
  end

  assign zero = (cnt_ff == EMST_CNT_ZERO);

endmodule

// file: core/emst_ctrl.sv
// Purpose: Sequencer for external bus cycles with programmable setup, strobe width and hold.
// Assumes: Core requests come from logic on clk; read data arrives from a pin and is synchronised.
// Notes:   A new request is taken only while idle; requests made while busy are ignored.
`timescale 1ns/10ps
module emst_ctrl (
  input  wire logic             clk,          // System clock, 20 MHz.
  input  wire logic             rst_b,        // Asynchronous reset, active low.
  input  wire logic [7:0]       sfr_addr,     // Special register address.
  input  wire logic             sfr_wr,       // Register write strobe, one cycle.
  input  wire logic             sfr_rd,       // Register read strobe, one cycle.
  input  wire logic [7:0]       sfr_wdata,    // Register write data.
  output logic      [7:0]       sfr_rdata,    // Register read data, valid the cycle after sfr_rd.
  input  wire logic             req_valid,    // Start a bus cycle, taken while idle.
  input  wire emst_pkg::emst_req_s req,       // Direction, address and write data.
  output logic                  busy,         // A bus cycle is in progress.
  output logic                  done,         // One-cycle pulse after the cycle ends.
  output logic      [7:0]       rd_data,      // Data captured by the last read.
  output logic      [15:0]      mem_addr,     // External address.
  output logic                  mem_rd_b,     // Read strobe, active low.
  output logic                  mem_wr_b,     // Write strobe, active low.
  output logic      [7:0]       mem_dout,     // Data bus output.
  output logic                  mem_doe,      // Data bus output enable, high while driving.
  input  wire logic [7:0]       mem_din       // Data bus input from the pin.
);
  import emst_pkg::*;

  emst_timing_s ctl_ff;
  emst_timing_s lat_ff;
  emst_req_s    req_ff;
  emst_state_e  state_ff;
  emst_state_e  nxt_state;
  logic [7:0]   sfr_rdata_ff;
  logic         busy_ff;
  logic         done_ff;
  logic [7:0]   rd_data_ff;
  logic [15:0]  mem_addr_ff;
  logic         mem_rd_b_ff;
  logic         mem_wr_b_ff;
  logic [7:0]   mem_dout_ff;
  logic         mem_doe_ff;
  logic [7:0]   din_meta_ff;
  logic [7:0]   din_sync_ff;
  logic         take;
  logic         finish;
  logic         tmr_load;
  logic [3:0]   tmr_val;
  logic         tmr_zero;
  logic         tc_hit_wr;
  logic         tc_hit_rd;
  logic [4:0]   run_len_ff;

  function automatic logic tc_hit(input logic [7:0] addr);
    tc_hit = (addr == EMST_TC_ADDR);
  endfunction

  assign tc_hit_wr = sfr_wr && tc_hit(sfr_addr);
  assign tc_hit_rd = sfr_rd && tc_hit(sfr_addr);

  ////////////////////////////////////////////////////////////////////////////////
  // Timing register.

  // The struct places setup in 7:6, width in 5:2 and hold in 1:0.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ctl_ff <= EMST_TC_RESET;
    end else if (tc_hit_wr) begin
      ctl_ff <= sfr_wdata;
    end
  end

  // Other addresses belong to other blocks, so this port answers zero to them.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sfr_rdata_ff <= 8'h00;
    end else if (tc_hit_rd) begin
      sfr_rdata_ff <= ctl_ff;
    end else begin
      sfr_rdata_ff <= 8'h00;
    end
  end

  a_hold_bits : assert property (@(posedge clk) disable iff (!rst_b)
    tc_hit_wr |=> (ctl_ff.hold == $past(sfr_wdata[1:0])) && (sfr_rdata_ff == 8'h00 || $past(sfr_rd)))
    else $error("hold field not taken from bits 1:0");

  ////////////////////////////////////////////////////////////////////////////////
  // Read data synchroniser.

  // The data pins change outside our control, so two flops sit before capture.
  // A limitation: read data must be valid two clocks before the strobe ends.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      din_meta_ff <= 8'h00;
      din_sync_ff <= 8'h00;
    end else begin
      din_meta_ff <= mem_din;
      din_sync_ff <= din_meta_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Phase sequencer.

  emst_phase_timer u_timer (
    .clk      (clk),
    .rst_b    (rst_b),
    .load     (tmr_load),
    .load_val (tmr_val),
    .zero     (tmr_zero)
  );

  always_comb begin
    nxt_state = state_ff;
    take      = 1'b0;
    finish    = 1'b0;
    tmr_load  = 1'b0;
    tmr_val   = EMST_CNT_ZERO;
    case (state_ff)
      ST_IDLE: begin
        if (req_valid) begin
          take     = 1'b1;
          tmr_load = 1'b1;
          if (ctl_ff.setup != 2'h0) begin
            nxt_state = ST_SETUP;
            tmr_val   = {2'h0, ctl_ff.setup} - EMST_CNT_ONE;
          end else begin
            nxt_state = ST_STROBE;
            tmr_val   = ctl_ff.width;
          end
        end
      end
      ST_SETUP: begin
        if (tmr_zero) begin
          nxt_state = ST_STROBE;
          tmr_load  = 1'b1;
          tmr_val   = lat_ff.width;
        end
      end
      ST_STROBE: begin
        if (tmr_zero) begin
          if (lat_ff.hold != 2'h0) begin
            nxt_state = ST_HOLD;
            tmr_load  = 1'b1;
            tmr_val   = {2'h0, lat_ff.hold} - EMST_CNT_ONE;
          end else begin
            nxt_state = ST_IDLE;
            finish    = 1'b1;
          end
        end
      end
      ST_HOLD: begin
        if (tmr_zero) begin
          nxt_state = ST_IDLE;
          finish    = 1'b1;
        end
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_ff <= ST_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Latching at the start keeps a register write mid-cycle from tearing the cycle.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      lat_ff <= EMST_TC_RESET;
      req_ff <= '0;
    end else if (take) begin
      lat_ff <= ctl_ff;
      req_ff <= req;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Pin and status outputs, all registered; only the strobes and busy come from the next state.

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      mem_addr_ff <= 16'h0000;
      mem_dout_ff <= 8'h00;
    end else if (take) begin
      mem_addr_ff <= req.addr;
      mem_dout_ff <= req.wdata;
    end
  end

  // Both strobes are driven from the same phase, so their width cannot differ.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      mem_rd_b_ff <= 1'b1;
      mem_wr_b_ff <= 1'b1;
    end else begin
      mem_rd_b_ff <= !((nxt_state == ST_STROBE) && !(take ? req.write : req_ff.write));
      mem_wr_b_ff <= !((nxt_state == ST_STROBE) && (take ? req.write : req_ff.write));
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      mem_doe_ff <= 1'b0;
    end else if (take) begin
      mem_doe_ff <= req.write;
    end else if (finish) begin
      mem_doe_ff <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      busy_ff <= 1'b0;
      done_ff <= 1'b0;
    end else begin
      busy_ff <= (nxt_state != ST_IDLE);
      done_ff <= finish;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rd_data_ff <= 8'h00;
    end else if ((state_ff == ST_STROBE) && tmr_zero && !req_ff.write) begin
      rd_data_ff <= din_sync_ff;
    end
  end

  assign sfr_rdata = sfr_rdata_ff;
  assign busy      = busy_ff;
  assign done      = done_ff;
  assign rd_data   = rd_data_ff;
  assign mem_addr  = mem_addr_ff;
  assign mem_rd_b  = mem_rd_b_ff;
  assign mem_wr_b  = mem_wr_b_ff;
  assign mem_dout  = mem_dout_ff;
  assign mem_doe   = mem_doe_ff;

  ////////////////////////////////////////////////////////////////////////////////
  // Checks.

  // Cycles spent so far in the current phase.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      run_len_ff <= EMST_RUN_ZERO;
    end else if (nxt_state != state_ff) begin
      run_len_ff <= EMST_RUN_ZERO;
    end else begin
      run_len_ff <= run_len_ff + 5'h01;
    end
  end

  a_setup_len : assert property (@(posedge clk) disable iff (!rst_b)
    (state_ff == ST_SETUP && nxt_state != ST_SETUP) |-> (run_len_ff + 5'h01 == {3'h0, lat_ff.setup}))
    else $error("setup interval length wrong");

  a_strobe_len : assert property (@(posedge clk) disable iff (!rst_b)
    (state_ff == ST_STROBE && nxt_state != ST_STROBE) |-> (run_len_ff == {1'b0, lat_ff.width}))
    else $error("strobe width wrong");

  a_shared_strobe : assert property (@(posedge clk) disable iff (!rst_b)
    ((mem_rd_b_ff && mem_wr_b_ff) == (state_ff != ST_STROBE)) && (mem_rd_b_ff || mem_wr_b_ff))
    else $error("strobe not tied to strobe phase");

  a_hold_len : assert property (@(posedge clk) disable iff (!rst_b)
    (state_ff == ST_HOLD && nxt_state != ST_HOLD) |-> (run_len_ff + 5'h01 == {3'h0, lat_ff.hold}))
    else $error("hold interval length wrong");

  a_addr_stable : assert property (@(posedge clk) disable iff (!rst_b)
    (busy_ff && $past(busy_ff) && !$past(take)) |-> $stable(mem_addr_ff) && $stable(mem_doe_ff))
    else $error("address moved during a cycle");

  a_phase_order : assert property (@(posedge clk) disable iff (!rst_b)
    (state_ff == ST_STROBE) |=> (state_ff inside {ST_STROBE, ST_HOLD, ST_IDLE}) && (state_ff != ST_SETUP))
    else $error("phase order broken");

  a_fields_fixed : assert property (@(posedge clk) disable iff (!rst_b)
    (busy_ff && !take) |=> $stable(lat_ff))
    else $error("fields changed mid cycle");

  a_done_pulse : assert property (@(posedge clk) disable iff (!rst_b)
    finish |=> done_ff && !busy_ff ##1 !done_ff)
    else $error("done pulse wrong");

endmodule

// file: bench/emst_mem_model.sv
// Purpose: Behavioural external byte memory on the far side of the strobe timing block.
// Assumes: Strobes are active low; only the low address byte selects a location.
// Notes:   A released data bus shows the inverse of its last value, so a late sample is caught.
`timescale 1ns/10ps
module emst_mem_model (
  input  wire logic        clk,       // System clock.
  input  wire logic        slow,      // Read data appears one clock after the strobe falls.
  input  wire logic [15:0] mem_addr,  // Address pins.
  input  wire logic        mem_rd_b,  // Read strobe, active low.
  input  wire logic        mem_wr_b,  // Write strobe, active low.
  input  wire logic [7:0]  mem_dout,  // Data from the controller.
  input  wire logic        mem_doe,   // Controller drives the data bus.
  output logic      [7:0]  mem_din    // Data towards the controller.
);
  logic [7:0] store [0:255];
  logic [7:0] last_ff = 8'h00;
  logic       rd_ff   = 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  always @(posedge clk) begin
    rd_ff   <= !mem_rd_b;
    last_ff <= mem_din;
    if (!mem_wr_b && mem_doe) begin
      store[mem_addr[7:0]] <= mem_dout;
    end
  end

  always_comb begin
    mem_din = (!mem_rd_b && (!slow || rd_ff)) ? store[mem_addr[7:0]] : ~last_ff;
  end
endmodule

// file: bench/tb.sv
// Purpose: Self-checking bench for the external bus strobe timing block.
// Assumes: Inputs change on the falling edge; every task starts and ends just after one.
// Notes:   Strobe, done and enable timing are measured cycle by cycle from the taking edge.
`timescale 1ns/10ps
module tb;
  import emst_pkg::*;
  logic        clk = 1'b0, rst_b = 1'b0, sfr_wr = 1'b0, sfr_rd = 1'b0, req_valid = 1'b0, slow = 1'b0;
  logic [7:0]  sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_rdata, rd_data, mem_dout, mem_din, got;
  logic [15:0] mem_addr;
  logic        busy, done, mem_rd_b, mem_wr_b, mem_doe;
  emst_req_s   req = '0;
  int          n_errors = 0, checked = 0, cycles = 0;
  logic [7:0]  tcs [7] = '{8'h00, 8'h55, 8'h86, 8'h4b, 8'h3c, 8'hb7, 8'h03};

  always #25 clk = ~clk;

  emst_ctrl dut_u (.clk, .rst_b, .sfr_addr, .sfr_wr, .sfr_rd, .sfr_wdata, .sfr_rdata, .req_valid, .req,
                   .busy, .done, .rd_data, .mem_addr, .mem_rd_b, .mem_wr_b, .mem_dout, .mem_doe, .mem_din);
  emst_mem_model mem_u (.clk, .slow, .mem_addr, .mem_rd_b, .mem_wr_b, .mem_dout, .mem_doe, .mem_din);

  ////////////////////////////////////////////////////////////////////////////
  task automatic test_done;
    $display("checked %0d, errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // A hung sequencer would otherwise stall the run forever.
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      n_errors++;
      $display("unexpected at %0t: run too long", $time);
      test_done();
    end
  end

  task automatic chk_d(input logic [15:0] g, input logic [15:0] x);
    checked++;
    if (g !== x) begin
      n_errors++;
      $display("unexpected at %0t: value %h, wanted %h", $time, g, x);
    end
  endtask

  task automatic chk_n(input int g, input int x);
    checked++;
    if (g != x) begin
      n_errors++;
      $display("unexpected at %0t: count %0d, wanted %0d", $time, g, x);
    end
  endtask

  task automatic sfr_w(input logic [7:0] a, input logic [7:0] d);
    sfr_addr  = a;
    sfr_wdata = d;
    sfr_wr    = 1'b1;
    @(negedge clk);
    sfr_wr    = 1'b0;
    @(negedge clk);
  endtask

  task automatic sfr_r(input logic [7:0] a);
    sfr_addr = a;
    sfr_rd   = 1'b1;
    @(negedge clk);
    sfr_rd   = 1'b0;
    got      = sfr_rdata;
    @(negedge clk);
  endtask

  // One bus cycle timed by tc; keep holds the request through the cycle, mid rewrites the register.
  task automatic run(input logic wr, input logic [7:0] tc, input logic keep, input int mid);
    int s, w, h, e, first, low;
    logic [15:0] a;
    s = tc[7:6];
    w = tc[5:2];
    h = tc[1:0];
    e = s + w + 1 + h;
    first = -1;
    low = 0;
    a = {tc, ~tc};
    req_valid = 1'b1;
    req = '{wr, a, tc ^ 8'h5a};
    for (int k = 0; k <= e; k++) begin
      @(negedge clk);
      if (!keep && k == 0) req_valid = 1'b0;
      if (mid >= 0 && k < 3) begin
        sfr_addr  = EMST_TC_ADDR;
        sfr_wdata = mid[7:0];
        sfr_wr    = (k == 1);
      end
      if ((wr ? mem_wr_b : mem_rd_b) === 1'b0) begin
        if (first < 0) first = k;
        low++;
      end
      chk_d(wr ? mem_rd_b : mem_wr_b, 1'b1);
      chk_d(mem_addr, a);
      chk_d(mem_dout, tc ^ 8'h5a);
      chk_d({busy, done, mem_doe}, {k < e, k == e, wr && k < e});
    end
    chk_n(first, s);
    chk_n(low, w + 1);
    // Read data passes two flops, so it must stand at the pins two clocks before the strobe ends.
    if (!wr && w >= 2 + slow) chk_d(rd_data, tc ^ 8'h5a);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    chk_d({busy, done, mem_rd_b, mem_wr_b, mem_doe}, 5'b00110);
    sfr_r(EMST_TC_ADDR);
    chk_d(got, 8'hff);
    run(1'b1, 8'hff, 1'b0, -1);
    $display("test reset done, errors %0d", n_errors);
  endtask

  task automatic t_fields;
    for (int i = 0; i < 7; i++) begin
      sfr_w(EMST_TC_ADDR, tcs[i]);
      sfr_r(EMST_TC_ADDR);
      chk_d(got, tcs[i]);
      run(1'b1, tcs[i], 1'b0, -1);
      slow = i[0];
      run(1'b0, tcs[i], 1'b0, -1);
    end
    $display("test fields done, errors %0d", n_errors);
  endtask

  task automatic t_regmap;
    sfr_w(8'hae, 8'h12);
    sfr_r(8'hae);
    chk_d(got, 8'h00);
    sfr_r(EMST_TC_ADDR);
    chk_d(got, 8'h03);
    $display("test regmap done, errors %0d", n_errors);
  endtask

  // The second request is held across the first cycle and taken in its done cycle.
  task automatic t_midwrite;
    sfr_w(EMST_TC_ADDR, 8'h45);
    run(1'b1, 8'h45, 1'b1, 8'h08);
    run(1'b1, 8'h08, 1'b0, -1);
    $display("test midwrite done, errors %0d", n_errors);
  endtask

  // A reset inside a write strobe must drop every pin back to idle at once.
  task automatic t_midreset;
    req_valid = 1'b1;
    req       = '{1'b1, 16'h1234, 8'h77};
    repeat (3) @(negedge clk);
    chk_d(mem_wr_b, 1'b0);
    rst_b     = 1'b0;
    req_valid = 1'b0;
    @(negedge clk);
    chk_d({busy, done, mem_rd_b, mem_wr_b, mem_doe}, 5'b00110);
    chk_d(mem_addr, 16'h0000);
    rst_b = 1'b1;
    sfr_r(EMST_TC_ADDR);
    chk_d(got, 8'hff);
    $display("test midreset done, errors %0d", n_errors);
  endtask

  initial begin
    repeat (16) @(posedge clk);
    @(negedge clk);
    rst_b = 1'b1;
    t_reset();
    t_fields();
    t_regmap();
    t_midwrite();
    t_midreset();
    test_done();
  end
endmodule
